/* src/frs_sequencer.sv */
/*
  front-end reset output sequencer: drives the active-low reset to the
  external video decoder. assumes inputs synchronous to CLK_I.
*/
// How it works
// R1 - reset output goes low at once while power-on sense is low
// R2 - after power-on sense returns high, output stays low until software release
// R3 - power-good or internal reset asserts the output about 5 us later
// R4 - output stays asserted at least 2 ms after software release
// R5 - software bit can drive the output level directly
// R6 - board ties factory test enable to ground in normal use
// R7 - test points left open; lowest three may get pull-up jumpers
// R8 - system-clock counter times the hold; release needs count and release both
`timescale 1ns/10ps
`default_nettype none
module frs_sequencer
  import frs_pkg::*;
#(
  parameter int unsigned HOLD_CYC = MIN_HOLD_CYC
)
(
  // clock and reset
  input  wire logic                 CLK_I,
  input  wire logic                 SYS_RST_I,
  // power and reset sources
  input  wire logic                 POWER_ON_SENSE_I,
  input  wire logic                 POWER_GOOD_INPUT_I,
  input  wire logic                 INT_RESET_I,
  // software control
  input  wire logic                 SW_RELEASE_I,
  input  wire logic                 SW_OVERRIDE_EN_I,
  input  wire logic                 SW_OVERRIDE_LEVEL_I,
  // straps and test pins
  input  wire logic                 FACTORY_TEST_ENABLE_I,
  input  wire logic [TEST_PT_W-1:0] TEST_POINT_PINS_I,
  output logic      [TEST_PT_W-1:0] TEST_POINT_PINS_O,
  output logic      [TEST_PT_W-1:0] TEST_POINT_PINS_OE_O,
  // front end
  output logic                      FRONTEND_RESET_N_O,
  output logic                      FACTORY_TEST_MODE_O,
  output logic                      SEQ_ASSERTED_O
);
  frs_state_t state;
  frs_state_t next_state;
  logic [7:0] dly_cnt;
  logic       pg_q;
  logic       trig;
  logic       reset_out;
  logic       pin_level;
  frs_timer_if tif ();

  frs_timer #(.COUNT(HOLD_CYC)) u_timer
  (
    .clk_i (CLK_I),
    .rst_i (SYS_RST_I),
    .tif   (tif.timer)
  );

  // edge of power-good plus any internal reset request
  assign trig = (POWER_GOOD_INPUT_I && !pg_q) || INT_RESET_I;

  always_ff @(posedge CLK_I)
  begin
    // idle high, so a power-good already up at reset is no edge
    if (SYS_RST_I)
      pg_q <= 1'b1;
    else
      pg_q <= POWER_GOOD_INPUT_I;
  end

  // R8 hold timer start
  assign tif.start = (state == FRS_HELD) && POWER_ON_SENSE_I && SW_RELEASE_I;

  always_comb
  begin
    next_state = state;
    case (state)
      FRS_HELD:
        // R2 wait software release
        if (POWER_ON_SENSE_I && SW_RELEASE_I)
          next_state = FRS_HOLD;
      FRS_HOLD:
        // R4 minimum hold; a trigger restarts it, pending would free the pin
        if (trig)
          next_state = FRS_HELD;
        else if (tif.done)
          next_state = FRS_RUN;
      FRS_RUN:
        if (trig)
          next_state = FRS_PENDING;
      FRS_PENDING:
        // R3 delayed assertion
        if (dly_cnt == 8'(ASSERT_DELAY_CYC - 1))
          next_state = FRS_HELD;
      default:
        next_state = FRS_HELD;
    endcase
    // R1 power-on sense low forces held state
    if (!POWER_ON_SENSE_I)
      next_state = FRS_HELD;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      state <= FRS_HELD;
    else
      state <= next_state;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I || state != FRS_PENDING)
      dly_cnt <= 8'h00;
    else
      dly_cnt <= dly_cnt + 8'h01;
  end

  // R1 combinational path so low sense acts at once
  assign reset_out = !POWER_ON_SENSE_I || state == FRS_HELD || state == FRS_HOLD;

  // R5 software override of the pin level
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      pin_level <= 1'b0;
    else if (SW_OVERRIDE_EN_I && POWER_ON_SENSE_I)
      pin_level <= SW_OVERRIDE_LEVEL_I;
    else
      pin_level <= !reset_out;
  end

  // R1 low sense gates the pin without waiting a clock
  assign FRONTEND_RESET_N_O = pin_level && POWER_ON_SENSE_I;

  assign SEQ_ASSERTED_O = reset_out;

  // R6 strap registered every clock after reset release, held low under reset
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      FACTORY_TEST_MODE_O <= 1'b0;
    else
      FACTORY_TEST_MODE_O <= FACTORY_TEST_ENABLE_I;
  end

  // R7 test points only driven in factory test; left undriven otherwise
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      TEST_POINT_PINS_O    <= TEST_PT_RST;
      TEST_POINT_PINS_OE_O <= TEST_PT_RST;
    end
    else
    begin
      TEST_POINT_PINS_O    <= {state, pg_q, reset_out, TEST_POINT_PINS_I[3:0]};
      TEST_POINT_PINS_OE_O <= {TEST_PT_W{FACTORY_TEST_MODE_O}};
    end
  end

  // assertions
  sequence s_release;
    state == FRS_HELD && POWER_ON_SENSE_I && SW_RELEASE_I;
  endsequence

  sequence s_trig_run;
    state == FRS_RUN && trig && POWER_ON_SENSE_I;
  endsequence

  // R1 pin low in the same cycle
  a_sense_low_out: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R1
    !POWER_ON_SENSE_I |-> !FRONTEND_RESET_N_O)
    else $error("reset output high while sense low");

  // R2 pin low while held
  a_held_out: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R2
    state == FRS_HELD && !SW_OVERRIDE_EN_I |=> !FRONTEND_RESET_N_O)
    else $error("reset output high while held");

  a_held_until_sw: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R2
    state == FRS_HELD && !SW_RELEASE_I |=> state == FRS_HELD)
    else $error("left held state without release");

  // R3 held within the delay
  a_trig_delay: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R3
    s_trig_run |-> ##[1:201] state == FRS_HELD)
    else $error("trigger did not assert in time");

  // R3 no early assertion
  a_pend_early: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R3
    state == FRS_PENDING && POWER_ON_SENSE_I && dly_cnt != 8'(ASSERT_DELAY_CYC - 1) |=> state == FRS_PENDING)
    else $error("pending delay cut short");

  // R4 pin low during hold
  a_hold_low: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R4
    state == FRS_HOLD && !SW_OVERRIDE_EN_I |=> !FRONTEND_RESET_N_O)
    else $error("reset output high during hold");

  // R4 trigger restarts hold
  a_hold_restart: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R4
    state == FRS_HOLD && trig |=> state == FRS_HELD)
    else $error("trigger in hold not restarted");

  a_min_hold: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R4
    s_release |=> state == FRS_HOLD || state == FRS_HELD || state == FRS_PENDING)
    else $error("hold skipped after release");

  a_override: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R5
    SW_OVERRIDE_EN_I && POWER_ON_SENSE_I |=> FRONTEND_RESET_N_O == ($past(SW_OVERRIDE_LEVEL_I) && POWER_ON_SENSE_I))
    else $error("override level not applied");

  a_timer_start: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R8
    s_release |=> !tif.done)
    else $error("hold timer done too early");

  a_test_pins: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R7
    !FACTORY_TEST_MODE_O |=> TEST_POINT_PINS_OE_O == '0)
    else $error("test points driven outside test");

  a_strap_follow: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R6
    ##1 FACTORY_TEST_MODE_O == $past(FACTORY_TEST_ENABLE_I))
    else $error("test strap not followed");
endmodule
`default_nettype wire

/* src/frs_pkg.sv */
/*
  package for the front-end reset sequencer: timing counts and state codes.
  assumes a 40 MHz system clock.
*/
`default_nettype none
package frs_pkg;
  localparam int unsigned CLK_HZ          = 40000000;
  // delay from power-good or internal reset to assertion, ns
  localparam int unsigned ASSERT_DELAY_NS = 5000;
  localparam int unsigned ASSERT_DELAY_CYC = (ASSERT_DELAY_NS * (CLK_HZ / 1000000)) / 1000;
  // least hold after software release, us
  localparam int unsigned MIN_HOLD_US     = 2000;
  localparam int unsigned MIN_HOLD_CYC    = MIN_HOLD_US * (CLK_HZ / 1000000);
  localparam int unsigned CNT_W           = 17;
  localparam int unsigned TEST_PT_W       = 8;
  localparam logic [TEST_PT_W-1:0] TEST_PT_RST = 8'h00;

  typedef enum logic [1:0]
  {
    FRS_HELD    = 2'b00,
    FRS_HOLD    = 2'b01,
    FRS_RUN     = 2'b10,
    FRS_PENDING = 2'b11
  } frs_state_t;
endpackage
`default_nettype wire

/* src/frs_if.sv */
/*
  interface between the sequencer and its hold timer.
  assumes one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
interface frs_timer_if;
  logic start;
  logic done;
  modport owner (output start, input done);
  modport timer (input start, output done);
endinterface
`default_nettype wire

/* src/frs_timer.sv */
/*
  down-counter timing a fixed number of cycles after a start pulse.
  assumes synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module frs_timer
  import frs_pkg::*;
#(
  parameter int unsigned COUNT = MIN_HOLD_CYC
)
(
  input wire logic    clk_i,
  input wire logic    rst_i,
  frs_timer_if.timer  tif
);
  logic [CNT_W-1:0] cnt;
  logic             running;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt     <= '0;
      running <= 1'b0;
    end
    else if (tif.start)
    begin
      cnt     <= CNT_W'(COUNT - 1);
      running <= 1'b1;
    end
    else if (running && cnt != '0)
    begin
      cnt <= cnt - CNT_W'(1);
    end
    else
    begin
      running <= 1'b0;
    end
  end

  assign tif.done = running && (cnt == '0);
endmodule
`default_nettype wire

/* testbench/frs_afe_model.sv */
/*
  video decoder stand-in: measures each low pulse of its reset pin.
  assumes the pin is sampled on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module frs_afe_model
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  output logic      [31:0] low_cyc_o
);
  logic [31:0] cnt;
  initial cnt = 0;
  initial low_cyc_o = 0;
  // decoder only sees the pulse width
  always @(posedge clk_i)
  begin
    if (rst_n_i !== 1'b1)
      cnt <= cnt + 1;
    else if (cnt != 0)
    begin
      low_cyc_o <= cnt;
      cnt       <= 0;
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
/*
  bench for the front-end reset sequencer.
  assumes a 40 MHz clock and a short hold count.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import frs_pkg::*;
  localparam int HC = 20;
  logic        clk = 0, rst = 1, sense = 0, pgood = 0, irst = 0;
  logic        rel = 0, ov_en = 0, ov_lv = 0, ftest = 0;
  // lowest three test points on pull-up jumpers
  logic [7:0]  tp_i = 8'h07;
  logic [7:0]  tp_o, tp_oe;
  logic        rst_n, ftm, seq_a;
  logic [31:0] low_cyc;
  int          fails = 0, n_compared = 0;
  always #12.5 clk = ~clk;
  frs_sequencer #(.HOLD_CYC(HC)) uut (.CLK_I(clk), .SYS_RST_I(rst), .POWER_ON_SENSE_I(sense),
    .POWER_GOOD_INPUT_I(pgood), .INT_RESET_I(irst), .SW_RELEASE_I(rel), .SW_OVERRIDE_EN_I(ov_en),
    .SW_OVERRIDE_LEVEL_I(ov_lv), .FACTORY_TEST_ENABLE_I(ftest), .TEST_POINT_PINS_I(tp_i),
    .TEST_POINT_PINS_O(tp_o), .TEST_POINT_PINS_OE_O(tp_oe), .FRONTEND_RESET_N_O(rst_n),
    .FACTORY_TEST_MODE_O(ftm), .SEQ_ASSERTED_O(seq_a));
  frs_afe_model afe (.clk_i(clk), .rst_n_i(rst_n), .low_cyc_o(low_cyc));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bounded wait for the reset pin level
  task automatic wait_out(input logic lv, input int lim);
    for (int i = 0; i < lim && rst_n !== lv; i++) @(negedge clk);
    check(rst_n, lv);
    if (rst_n !== lv) give_verdict();
  endtask
  task automatic t_sense;
    sense = 0;
    cyc(1);
    check(rst_n, 0);
    cyc(5);
    check(seq_a, 1);
    sense = 1;
    cyc(30);
    check(rst_n, 0);
  endtask
  task automatic t_release;
    rel = 1;
    cyc(HC);
    check(rst_n, 0);
    wait_out(1, 6);
    cyc(1);
    check(low_cyc >= HC, 1);
  endtask
  // trigger with release held: output must still wait the hold
  task automatic t_trigger(input logic use_pg);
    if (use_pg) pgood = 1; else irst = 1;
    cyc(1);
    irst = 0;
    cyc(150);
    check(rst_n, 1);
    wait_out(0, 100);
    pgood = 0;
    wait_out(1, HC + 6);
    cyc(1);
    check(low_cyc >= HC, 1);
  endtask
  // trigger inside the hold must restart it, pin stays low
  task automatic t_hold_trig;
    sense = 0;
    cyc(3);
    sense = 1;
    cyc(5);
    irst = 1;
    cyc(1);
    irst = 0;
    cyc(HC - 2);
    check(rst_n, 0);
    wait_out(1, 12);
    cyc(1);
    check(low_cyc >= HC + 5, 1);
  endtask
  task automatic t_override;
    ov_en = 1;
    cyc(3);
    check(rst_n, 0);
    ov_lv = 1;
    cyc(3);
    check(rst_n, 1);
    sense = 0;
    cyc(3);
    check(rst_n, 0);
    sense = 1;
    ov_en = 0;
    wait_out(1, HC + 8);
  endtask
  task automatic t_strap;
    check(tp_oe, 8'h00);
    ftest = 1;
    cyc(3);
    check(ftm, 1);
    check(tp_oe, 8'hff);
    // board grounds the strap in normal use
    ftest = 0;
    cyc(3);
    check(ftm, 0);
    check(tp_oe, 8'h00);
  endtask
  initial
  begin
    cyc(20);
    rst = 0;
    t_sense();
    t_release();
    t_trigger(0);
    t_trigger(1);
    t_override();
    t_hold_trig();
    t_strap();
    give_verdict();
  end
  // hang guard
  initial
  begin
    #2000000;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
